/* File: hdl/vspf_pkg.sv */
`default_nettype none
package vspf_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int RTC_HZ = 10_000_000;
  localparam int RTC_W  = 48;
  localparam int ACC_W  = 25;

  // ----------------------------------------------------------------
  // Stream clock reference conversion
  // ----------------------------------------------------------------
  localparam int SCR_BASE_W = 33;
  localparam int SCR_EXT_W  = 9;
  localparam int DIVD_W     = 46;
  localparam logic [DIVD_W-1:0] SCR_BASE_MUL = 46'h0000_0000_012C;
  localparam logic [DIVD_W-1:0] RTC_MUL      = 46'h0000_0000_000A;
  localparam logic [5:0]        SCR_DIV      = 6'h1B;
  // Half the divisor, added before dividing to round to nearest.
  localparam logic [DIVD_W-1:0] ROUND_ADD    = 46'h0000_0000_000D;
  localparam logic [5:0]        DIV_STEPS    = 6'h2E;

  // ----------------------------------------------------------------
  // Channel specific word layout and reset values
  // ----------------------------------------------------------------
  localparam int AUDIO_BIT   = 26;
  localparam int TIER_LSB    = 22;
  localparam int KLV_BIT     = 21;
  localparam int SYNC_BIT    = 20;
  localparam int STAMP_BIT   = 19;
  localparam int PROFILE_LSB = 15;
  localparam int ETIME_BIT   = 14;
  localparam int RATE_BIT    = 13;
  localparam int TYPE_BIT    = 12;
  localparam int COUNT_LSB   = 0;
  localparam int COUNT_W     = 12;
  localparam int WORD_W      = 32;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [11:0] COUNT_ONE = 12'h001;
  localparam logic [11:0] COUNT_ZERO = 12'h000;

  typedef enum logic [3:0] {
    PROF_BASELINE = 4'h0,
    PROF_MAIN     = 4'h1,
    PROF_EXTENDED = 4'h2,
    PROF_HIGH     = 4'h3,
    PROF_HIGH10   = 4'h4,
    PROF_HIGH422  = 4'h5,
    PROF_HIGH444  = 4'h6
  } vspf_profile_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CSDW = 5'b00010,
    ST_STLO = 5'b00100,
    ST_STHI = 5'b01000,
    ST_DATA = 5'b10000
  } vspf_state_t;

  // Assembles the channel specific word; bits above the audio bit stay zero.
  function automatic logic [31:0] buildCsdw(input logic audio, input logic [3:0] tier, input logic klv,
                                            input logic sync, input logic stamp, input logic [3:0] profile,
                                            input logic etime, input logic rate, input logic ptype,
                                            input logic [11:0] count);
    logic [31:0] w;
    w = WORD_RST;
    w[AUDIO_BIT] = audio;
    w[TIER_LSB +: 4] = tier;
    w[KLV_BIT] = klv;
    w[SYNC_BIT] = sync;
    w[STAMP_BIT] = stamp;
    w[PROFILE_LSB +: 4] = profile;
    w[ETIME_BIT] = etime;
    w[RATE_BIT] = rate;
    w[TYPE_BIT] = ptype;
    w[COUNT_LSB +: COUNT_W] = count;
    return w;
  endfunction

  // Rounded dividend: (base * 300 + ext) * 10 + 13.
  function automatic logic [DIVD_W-1:0] scrDividend(input logic [32:0] base, input logic [8:0] ext);
    logic [DIVD_W-1:0] scr;
    scr = DIVD_W'(DIVD_W'(base) * SCR_BASE_MUL) + DIVD_W'(ext);
    return DIVD_W'(scr * RTC_MUL) + ROUND_ADD;
  endfunction

endpackage
`default_nettype wire

/* File: hdl/vspf_rtc.sv */
`default_nettype none
// ------------------------------------------------------------------
// Relative time counter at 10 MHz derived from the system clock
// ------------------------------------------------------------------
module vspf_rtc (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  output logic [47:0]      rtcValue
);

  logic [vspf_pkg::ACC_W-1:0] acc_r;
  logic                       tick;

  // Fractional divider: two ticks every five clocks, no second clock needed.
  assign tick = (acc_r + vspf_pkg::ACC_W'(vspf_pkg::RTC_HZ)) >= vspf_pkg::ACC_W'(vspf_pkg::CLK_HZ);

  // Phase accumulator.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_r <= '0;
    end else if (tick) begin
      acc_r <= acc_r + vspf_pkg::ACC_W'(vspf_pkg::RTC_HZ) - vspf_pkg::ACC_W'(vspf_pkg::CLK_HZ);
    end else begin
      acc_r <= acc_r + vspf_pkg::ACC_W'(vspf_pkg::RTC_HZ);
    end
  end

  // Counter advances on each enable pulse.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rtcValue <= '0;
    end else if (tick) begin
      rtcValue <= rtcValue + 48'h0000_0000_0001;
    end
  end

endmodule // vspf_rtc
`default_nettype wire

/* File: hdl/vspf_scr_conv.sv */
`default_nettype none
// ------------------------------------------------------------------
// Stream clock reference to 10 MHz time, one quotient bit per clock
// ------------------------------------------------------------------
module vspf_scr_conv (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [32:0] scrBase,
  input  wire logic [8:0]  scrExt,
  input  wire logic        scrStart,
  output logic [47:0]      rtcOut,
  output logic             rtcDone,
  output logic             busy
);

  logic [45:0] num_r;
  logic [5:0]  rem_r;
  logic [5:0]  cnt_r;
  logic [5:0]  remSh;
  logic        qBit;

  // A serial divider trades 46 cycles of latency for a tiny footprint.
  assign remSh = {rem_r[4:0], num_r[45]};
  assign qBit  = remSh >= vspf_pkg::SCR_DIV;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      num_r   <= '0;
      rem_r   <= '0;
      cnt_r   <= '0;
      busy    <= 1'b0;
      rtcDone <= 1'b0;
      rtcOut  <= '0;
    end else begin
      rtcDone <= 1'b0;
      if (scrStart && !busy) begin
        num_r <= vspf_pkg::scrDividend(scrBase, scrExt);
        rem_r <= '0;
        cnt_r <= vspf_pkg::DIV_STEPS;
        busy  <= 1'b1;
      end else if (busy) begin
        rem_r <= qBit ? remSh - vspf_pkg::SCR_DIV : remSh;
        num_r <= {num_r[44:0], qBit};
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          busy    <= 1'b0;
          rtcDone <= 1'b1;
          rtcOut  <= {2'b00, num_r[44:0], qBit};
        end
      end
    end
  end

endmodule // vspf_scr_conv
`default_nettype wire

/* File: hdl/vspf_framer.sv */
`default_nettype none
module vspf_framer (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Configuration from the recorder channel setup.
  input  wire logic        timestamp_insert_flag,
  input  wire logic [3:0]  coding_profile_field,
  input  wire logic        embedded_time_flag,
  input  wire logic        bit_rate_mode_flag,
  input  wire logic        stream_type_flag,
  input  wire logic        audio_coding_flag,
  input  wire logic [3:0]  coding_tier_field,
  input  wire logic        metadata_flag,
  input  wire logic        clock_sync_flag,
  input  wire logic [11:0] recordPkts,
  input  wire logic        countKnown,
  input  wire logic        absTimeSel,
  input  wire logic [63:0] absTime,
  // Carried packets from the encoder.
  input  wire logic [31:0] inData,
  input  wire logic        inValid,
  input  wire logic        inFirst,
  input  wire logic        inLast,
  output logic             inReady,
  // Recorder packet body towards assembly.
  output logic [31:0]      outData,
  output logic             outValid,
  output logic             outFirst,
  output logic             outLast,
  input  wire logic        outReady,
  // Reference conversion and time base.
  input  wire logic [32:0] scrBase,
  input  wire logic [8:0]  scrExt,
  input  wire logic        scrStart,
  output logic [47:0]      scrRtc,
  output logic             scrRtcDone,
  output logic             scrBusy,
  output logic [47:0]      rtcValue
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vspf_pkg::vspf_state_t state_r;
  vspf_pkg::vspf_state_t state_nxt;
  logic        stampOn_r;
  logic [11:0] pktLeft_r;
  logic [31:0] stampHi_r;
  logic [31:0] skidData_r;
  logic        skidLast_r;
  logic        skidFull_r;
  logic        skidFull_nxt;
  logic        adv;
  logic        take;
  logic        lastRec;
  logic        slot;
  logic        emit;
  logic        emitFirst;
  logic [31:0] emitWord;
  logic [11:0] countField;
  logic [63:0] stampNow;

  // ----------------------------------------------------------------
  // Time sources
  // ----------------------------------------------------------------
  vspf_rtc u_rtc (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .rtcValue (rtcValue)
  );

  vspf_scr_conv u_conv (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .scrBase  (scrBase),
    .scrExt   (scrExt),
    .scrStart (scrStart),
    .rtcOut   (scrRtc),
    .rtcDone  (scrRtcDone),
    .busy     (scrBusy)
  );

  // Stamp source for the packet now starting.
  always_comb begin
    if (absTimeSel) begin
      stampNow = absTime;
    end else begin
      stampNow = {16'h0000, rtcValue};
    end
  end

  // ----------------------------------------------------------------
  // Output slot and handshake terms
  // ----------------------------------------------------------------
  // The output register is free when empty or being drained this cycle.
  assign adv     = !outValid || outReady;
  assign take    = inValid && inReady;
  assign lastRec = pktLeft_r == vspf_pkg::COUNT_ONE;
  // Generated words wait for the skid to empty so order is never swapped.
  assign slot    = adv && !skidFull_r;

  // The field follows the setting, while closing always uses the packet counter.
  // unknown count written zero.
  assign countField = countKnown ? recordPkts : vspf_pkg::COUNT_ZERO;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // One word per header or stamp state; the stamp halves sit between packets only.
  always_comb begin
    state_nxt = state_r;
    emit      = 1'b0;
    emitFirst = 1'b0;
    emitWord  = vspf_pkg::WORD_RST;
    unique case (state_r)
      vspf_pkg::ST_IDLE: begin
        // A record opened mid-packet would split a packet, so non-first words wait here.
        // The encoder must therefore stay aligned to packet starts.
        // start on packet boundary.
        if (inValid && inFirst) begin
          state_nxt = vspf_pkg::ST_CSDW;
        end
      end
      vspf_pkg::ST_CSDW: begin
        if (slot) begin
          emit      = 1'b1;
          emitFirst = 1'b1;
          emitWord  = vspf_pkg::buildCsdw(audio_coding_flag, coding_tier_field, metadata_flag,
                                          clock_sync_flag, timestamp_insert_flag, coding_profile_field,
                                          embedded_time_flag, bit_rate_mode_flag, stream_type_flag,
                                          countField);
          state_nxt = timestamp_insert_flag ? vspf_pkg::ST_STLO : vspf_pkg::ST_DATA;
        end
      end
      vspf_pkg::ST_STLO: begin
        // Waiting for valid ties the stamp instant to the first word, not to an idle gap.
        // stamp taken as first word waits.
        if (slot && inValid) begin
          emit      = 1'b1;
          emitWord  = stampNow[31:0];
          state_nxt = vspf_pkg::ST_STHI;
        end
      end
      vspf_pkg::ST_STHI: begin
        if (slot) begin
          emit      = 1'b1;
          emitWord  = stampHi_r;
          state_nxt = vspf_pkg::ST_DATA;
        end
      end
      vspf_pkg::ST_DATA: begin
        // Packet words pass straight through; only a last word moves the sequencer.
        // close only after a whole packet.
        if (take && inLast) begin
          if (lastRec) begin
            state_nxt = vspf_pkg::ST_IDLE;
          end else begin
            state_nxt = stampOn_r ? vspf_pkg::ST_STLO : vspf_pkg::ST_DATA;
          end
        end
      end
      default: begin
        state_nxt = vspf_pkg::ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= vspf_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Per-record settings are frozen with the channel word.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stampOn_r <= 1'b0;
      pktLeft_r <= vspf_pkg::COUNT_ZERO;
    end else if (state_r == vspf_pkg::ST_CSDW && slot) begin
      stampOn_r <= timestamp_insert_flag;
      // A zero setting still closes after one packet rather than never.
      pktLeft_r <= (recordPkts == vspf_pkg::COUNT_ZERO) ? vspf_pkg::COUNT_ONE : recordPkts;
    end else if (take && inLast) begin
      pktLeft_r <= pktLeft_r - vspf_pkg::COUNT_ONE;
    end
  end

  // Upper stamp half is held from the same instant as the lower.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stampHi_r <= vspf_pkg::WORD_RST;
    end else if (state_r == vspf_pkg::ST_STLO && emit) begin
      stampHi_r <= stampNow[63:32];
    end
  end

  // ----------------------------------------------------------------
  // Skid register and ready
  // ----------------------------------------------------------------
  // Ready is registered, so one word may arrive while the output stalls.
  always_comb begin
    skidFull_nxt = skidFull_r;
    if (adv) begin
      skidFull_nxt = 1'b0;
    end else if (take) begin
      skidFull_nxt = 1'b1;
    end
  end

  // Skid storage.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      skidFull_r <= 1'b0;
      skidData_r <= vspf_pkg::WORD_RST;
      skidLast_r <= 1'b0;
    end else begin
      skidFull_r <= skidFull_nxt;
      if (!adv && take) begin
        skidData_r <= inData;
        skidLast_r <= inLast && lastRec;
      end
    end
  end

  // Accept data only in the data phase with the skid free.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inReady <= 1'b0;
    end else begin
      inReady <= (state_nxt == vspf_pkg::ST_DATA) && !skidFull_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Skid first, then fresh input, then generated words.
  // A word already taken cannot be refused, so data outranks generated words.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      outData  <= vspf_pkg::WORD_RST;
      outValid <= 1'b0;
      outFirst <= 1'b0;
      outLast  <= 1'b0;
    end else if (adv) begin
      if (skidFull_r) begin
        outData  <= skidData_r;
        outValid <= 1'b1;
        outFirst <= 1'b0;
        outLast  <= skidLast_r;
      end else if (take) begin
        outData  <= inData;
        outValid <= 1'b1;
        outFirst <= 1'b0;
        outLast  <= inLast && lastRec; // Record ends on a packet end.
      end else if (emit) begin
        outData  <= emitWord;
        outValid <= 1'b1;
        outFirst <= emitFirst;
        outLast  <= 1'b0;
      end else begin
        outValid <= 1'b0;
        outFirst <= 1'b0;
        outLast  <= 1'b0;
      end
    end
  end

endmodule // vspf_framer
`default_nettype wire

/* File: tb/vspf_checker.sv */
`default_nettype none
// ------------------------------------------
// Port checker for the packet framer
// ------------------------------------------
module vspf_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        timestamp_insert_flag,
  input wire logic [3:0]  coding_profile_field,
  input wire logic        embedded_time_flag,
  input wire logic        bit_rate_mode_flag,
  input wire logic        stream_type_flag,
  input wire logic        audio_coding_flag,
  input wire logic [3:0]  coding_tier_field,
  input wire logic        metadata_flag,
  input wire logic        clock_sync_flag,
  input wire logic [11:0] recordPkts,
  input wire logic        countKnown,
  input wire logic        absTimeSel,
  input wire logic [31:0] outData,
  input wire logic        outValid,
  input wire logic        outFirst,
  input wire logic        outReady,
  input wire logic        scrStart,
  input wire logic        scrRtcDone,
  input wire logic        scrBusy,
  input wire logic [47:0] rtcValue
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // The header word is the beat flagged first.
  wire logic hdr = outValid && outFirst;

  AST_HDR_UPPER: assert property (hdr |-> outData[31:20] ==
    {5'h00, audio_coding_flag, coding_tier_field, metadata_flag, clock_sync_flag})
    else $error("header upper fields wrong");
  AST_HDR_LOWER: assert property (hdr |-> outData[18:12] ==
    {coding_profile_field, embedded_time_flag, bit_rate_mode_flag, stream_type_flag})
    else $error("header lower fields wrong");
  AST_HDR_STAMP: assert property (hdr |-> outData[19] == timestamp_insert_flag)
    else $error("stamp flag wrong");
  AST_HDR_COUNT: assert property (hdr |-> outData[11:0] == (countKnown ? recordPkts : 12'h000))
    else $error("packet count wrong");
  AST_OUT_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("stalled word changed");
  AST_HI_ZERO: assert property (hdr && outReady && timestamp_insert_flag && !absTimeSel
    ##1 outValid && outReady |=> outValid && outData[31:16] == 16'h0000)
    else $error("relative stamp high bits not zero");
  AST_SCR_LAT: assert property (scrStart && !scrBusy |-> ##47 scrRtcDone)
    else $error("conversion latency wrong");
  AST_SCR_END: assert property ($rose(scrRtcDone) |-> $past(scrBusy))
    else $error("done without conversion");
  AST_RTC_STEP: assert property (rtcValue == $past(rtcValue) ||
    rtcValue == $past(rtcValue) + 48'h0000_0000_0001)
    else $error("time counter jumped");
endmodule // vspf_checker

bind vspf_framer vspf_checker u_chk (.clk_sys, .rst, .timestamp_insert_flag, .coding_profile_field,
  .embedded_time_flag, .bit_rate_mode_flag, .stream_type_flag, .audio_coding_flag, .coding_tier_field,
  .metadata_flag, .clock_sync_flag, .recordPkts, .countKnown, .absTimeSel, .outData, .outValid,
  .outFirst, .outReady, .scrStart, .scrRtcDone, .scrBusy, .rtcValue);
`default_nettype wire

/* File: tb/vspf_enc_model.sv */
`default_nettype none
// ------------------------------------------
// Encoder model sending carried packets
// ------------------------------------------
module vspf_enc_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [11:0] nPkts,
  input  wire logic [11:0] nWords,
  input  wire logic        inReady,
  output logic [31:0]      inData,
  output var logic         inValid,
  output logic             inFirst,
  output logic             inLast
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        act;
  logic [11:0] pk;
  logic [11:0] w;
  // Idle data is inverted so a stale word never passes for a good one.
  assign inData  = inValid ? {4'hD, pk, 4'h0, w} : ~{4'hD, pk, 4'h0, w};
  assign inFirst = inValid && (w == 12'h000);
  assign inLast  = inValid && (w == nWords - 12'h001);
  // Whole packets only; slow mode drops valid after each word.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act <= 1'b0;
      inValid <= 1'b0;
      pk <= 12'h000;
      w <= 12'h000;
    end else if (!act) begin
      if (start) begin
        act <= 1'b1;
        inValid <= 1'b1;
        pk <= 12'h000;
        w <= 12'h000;
      end
    end else if (inValid && inReady) begin
      inValid <= !slow;
      if (w != nWords - 12'h001) begin
        w <= w + 12'h001;
      end else begin
        w <= 12'h000;
        pk <= pk + 12'h001;
        if (pk == nPkts - 12'h001) begin
          act <= 1'b0;
          inValid <= 1'b0;
        end
      end
    end else begin
      inValid <= 1'b1;
    end
  end
endmodule // vspf_enc_model
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------
  // Stimulus, monitor and scoreboard
  // ------------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        outReady = 1'b1;
  logic        stampOn, etime, rate, ptype, audio, klv, sync, known, absSel, start, slow, scrStart, stallOn;
  logic [3:0]  prof, tier;
  logic [11:0] nPk, nW;
  logic [32:0] scrBase;
  logic [8:0]  scrExt;
  logic [63:0] absTime = 64'h0123_4567_89AB_CDEF;
  logic [31:0] inData, outData;
  logic        inValid, inFirst, inLast, inReady, outValid, outFirst, outLast, scrRtcDone, scrBusy;
  logic [47:0] scrRtc, rtcValue;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  typedef struct {logic [31:0] d; logic l; logic [47:0] t; logic f;} vspf_beat_t;
  typedef struct {logic [3:0] p; logic [7:0] m; logic [11:0] n; logic [11:0] e;} vspf_row_t;
  vspf_beat_t  mon[$];
  // Flags: stamp, audio, metadata, sync, embedded time, rate, type, count known.
  vspf_row_t   rows[8] = '{'{4'h0, 8'h01, 12'h001, 12'h001}, '{4'h1, 8'h80, 12'h002, 12'h000},
    '{4'h2, 8'h43, 12'h003, 12'h003}, '{4'h3, 8'hA5, 12'h002, 12'h002}, '{4'h4, 8'h19, 12'h001, 12'h001},
    '{4'h5, 8'hFF, 12'h004, 12'h004}, '{4'h6, 8'h02, 12'h001, 12'h000}, '{4'h7, 8'h81, 12'h001, 12'h001}};
  logic [32:0] sb[3] = '{33'h0_0000_0001, 33'h1_FFFF_FFFF, 33'h0_0000_0000};
  logic [8:0]  se[3] = '{9'h000, 9'h12B, 9'h002};

  vspf_framer dut (.clk_sys, .rst, .timestamp_insert_flag(stampOn), .coding_profile_field(prof),
    .embedded_time_flag(etime), .bit_rate_mode_flag(rate), .stream_type_flag(ptype),
    .audio_coding_flag(audio), .coding_tier_field(tier), .metadata_flag(klv), .clock_sync_flag(sync),
    .recordPkts(nPk), .countKnown(known), .absTimeSel(absSel), .absTime, .inData, .inValid, .inFirst,
    .inLast, .inReady, .outData, .outValid, .outFirst, .outLast, .outReady, .scrBase, .scrExt,
    .scrStart, .scrRtc, .scrRtcDone, .scrBusy, .rtcValue);
  vspf_enc_model u_enc (.clk_sys, .rst, .start, .slow, .nPkts(nPk), .nWords(nW), .inReady, .inData,
    .inValid, .inFirst, .inLast);

  // Clock, sink stall pattern, monitor and a hang guard sized well above the run.
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) #1 outReady <= stallOn ? ~outReady : 1'b1;
  always @(posedge clk_sys) if (!rst && outValid && outReady) mon.push_back('{outData, outLast, rtcValue, outFirst});
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic step(input int k = 1);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic run_rec();
    int i;
    mon.delete();
    start = 1'b1;
    step();
    start = 1'b0;
    i = 0;
    while (!(mon.size() > 0 && mon[$].l === 1'b1) && i < 20000) begin
      step();
      i++;
    end
    check("record end", i < 20000, 1'b1);
  endtask

  // Walks one record: header, then per packet optional stamp and its words.
  task automatic verify(input logic [31:0] hdr);
    int k;
    logic [63:0] ts;
    k = 1;
    check("header", mon[0].d, hdr);
    check("first flag", mon[0].f, 1'b1);
    check("word count", mon.size(), 1 + nPk * (nW + (stampOn ? 2 : 0)));
    for (int p = 0; p < nPk; p++) begin
      if (stampOn) begin
        ts = {mon[k+1].d, mon[k].d};
        if (absSel) check("abs stamp", ts, absTime);
        else check("rel stamp", {ts[63:48], 1'b0, (mon[k].t - ts[47:0]) < 4}, 18'h0_0001);
        k += 2;
      end
      for (int w = 0; w < nW; w++) begin
        check("data", mon[k].d, {4'hD, 12'(p), 4'h0, 12'(w)});
        k++;
      end
    end
    check("last flag", mon[k-1].l, 1'b1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    {stampOn, etime, rate, ptype, audio, klv, sync, known, absSel, start, slow, scrStart, stallOn} = '0;
    {prof, tier, scrBase, scrExt} = '0;
    nPk = 12'h001;
    nW = 12'h002;
    step(4);
    check("reset outputs", {outValid, inReady, scrBusy, rtcValue}, 51'h0);
    rst = 1'b0;
    $display("reset test done");
    absSel = 1'b1;
    foreach (rows[i]) begin
      {stampOn, audio, klv, sync, etime, rate, ptype, known} = rows[i].m;
      prof = rows[i].p;
      tier = 4'hF - 4'(i);
      nPk = rows[i].n;
      run_rec();
      verify({5'h00, audio, tier, klv, sync, stampOn, prof, etime, rate, ptype, rows[i].e});
      $display("row %0d done", i);
    end
    // Mid-record reset must silence the outputs and clear the time base.
    nPk = 12'h032;
    start = 1'b1;
    step();
    start = 1'b0;
    step(20);
    rst = 1'b1;
    step(2);
    check("mid reset", {outValid, inReady, rtcValue}, 50'h0);
    rst = 1'b0;
    $display("mid reset test done");
    {stampOn, absSel, nPk, nW} = {1'b1, 1'b0, 12'h002, 12'h003};
    run_rec();
    verify({5'h00, audio, tier, klv, sync, 1'b1, prof, etime, rate, ptype, 12'h002});
    $display("relative stamp test done");
    {stampOn, absSel, nPk, nW, stallOn, slow} = {1'b0, 1'b1, 12'h003, 12'h001, 1'b1, 1'b1};
    run_rec();
    verify({5'h00, audio, tier, klv, sync, 1'b0, prof, etime, rate, ptype, 12'h003});
    {stallOn, slow, nPk} = {1'b0, 1'b0, 12'hFFF};
    run_rec();
    verify({5'h00, audio, tier, klv, sync, 1'b0, prof, etime, rate, ptype, 12'hFFF});
    $display("stall and full count tests done");
    // Top base sits at the rollover edge; counting rollovers is left to the stamp reader.
    for (int i = 0; i < 3; i++) begin
      longint ex;
      int n;
      {scrBase, scrExt} = {sb[i], se[i]};
      ex = ((longint'(scrBase) * 300 + scrExt) * 10 + 13) / 27;
      scrStart = 1'b1;
      step();
      scrBase = 33'h0_0000_0005;
      step();
      scrStart = 1'b0;
      // Counts the edges after the taking edge until done is visible.
      n = 1;
      while (scrRtcDone !== 1'b1 && n < 100) begin
        step();
        n++;
      end
      check("scr latency", n, 46);
      check("scr value", scrRtc, ex[47:0]);
    end
    $display("conversion test done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
